/* core/eic_pkg.sv */
// package for the encoder input conditioning block: offsets, fields, resets, carriers
// assumes a single peripheral bus clock and an AHB-Lite register port
package eic_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] EIC_OFS_CLK_DIS = 8'h00;
  localparam logic [7:0] EIC_OFS_ROUTE = 8'h04;
  localparam logic [7:0] EIC_OFS_ERR_SEL = 8'h08;
  localparam logic [7:0] EIC_OFS_FILT_W = 8'h0C;
  localparam logic [7:0] EIC_OFS_STATUS = 8'h10;
  localparam logic [7:0] EIC_OFS_MASK = 8'h14;
  localparam logic [7:0] EIC_OFS_LEVELS = 8'h18;

  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int EIC_CLK_DIS_BIT = 9;
  localparam int EIC_ROUTE_STRIDE = 8;
  localparam int EIC_ROUTE_SYNC_BIT = 0;
  localparam int EIC_ROUTE_FILT_BIT = 1;
  localparam int EIC_UNITS = 2;
  localparam int EIC_INPUTS = 4;
  localparam int EIC_FILT_W_BITS = 8;
  localparam logic [31:0] EIC_ROUTE_RST = 32'h0101_0101;
  localparam logic [7:0] EIC_FILT_W_RST = 8'h03;
  localparam logic [1:0] EIC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] EIC_HTRANS_SEQ = 2'h3;
  localparam logic EIC_HRESP_OKAY = 1'b0;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic strobe_input;
    logic index_input;
    logic phase_b_input;
    logic phase_a_input;
  } eic_enc_pins_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } eic_ahb_req_t;

endpackage

/* core/eic_sync_filter.sv */
// one encoder input: two-flop synchroniser, stability filter, route select
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module eic_sync_filter
  import eic_pkg::*;
#(
  parameter int W_BITS = EIC_FILT_W_BITS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic pin_i,
  input wire logic [1:0] route_i,
  input wire logic [W_BITS-1:0] width_i,
  output logic out_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic filt;
    logic [W_BITS-1:0] cnt;
    logic out;
  } eic_sf_state_t;

  eic_sf_state_t st_reg;
  eic_sf_state_t st_next;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_i;
    st_next.s2 = st_reg.s1;
    // level moves only after width cycles of stability
    if (st_reg.s2 != st_reg.filt) begin
      if ((st_reg.cnt + W_BITS'(1)) >= width_i) begin
        st_next.filt = st_reg.s2;
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt + W_BITS'(1);
      end
    end else begin
      st_next.cnt = '0;
    end
    // neither route bit set: unit sees a quiet low
    if (route_i[EIC_ROUTE_SYNC_BIT]) begin
      st_next.out = st_reg.s2;
    end else if (route_i[EIC_ROUTE_FILT_BIT]) begin
      st_next.out = st_reg.filt;
    end else begin
      st_next.out = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_o = st_reg.out;

endmodule
`default_nettype wire

/* core/eic_phase_check.sv */
// illegal quadrature transition detector for one encoder unit
// assumes conditioned, synchronous phase inputs
`timescale 1ns/100ps
`default_nettype none
module eic_phase_check
  import eic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  input wire logic phase_a_i,
  input wire logic phase_b_i,
  output logic err_o
);

  typedef struct packed {
    logic a;
    logic b;
    logic err;
  } eic_pc_state_t;

  eic_pc_state_t st_reg;
  eic_pc_state_t st_next;

  // ------------------------------------------------------------
  // both phases toggling at once skips a gray step
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.err = 1'b0;
    if (en_i) begin
      st_next.a = phase_a_i;
      st_next.b = phase_b_i;
      st_next.err = (phase_a_i != st_reg.a) && (phase_b_i != st_reg.b);
    end
  end

  // gated domain: stored phases frozen and error held low while disabled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign err_o = st_reg.err;

endmodule
`default_nettype wire

/* core/eic_top.sv */
// encoder input conditioning: clock-domain gate, input routing, phase error mux
// assumes AHB-Lite single word transfers and a free running clk_i
//
// Contract
// - bit 9 gates encoder clock domain only
// - encoder clock enabled out of reset
// - unit flags illegal phase A/B transition
// - selection mux picks which unit's error
// - mux output inverted to timer coprocessor
// - inputs double synchronised, optionally filtered
// - phase A route: bit0 sync, bit1 filtered
// - phase B route: bit8 sync, bit9 filtered
// - index route: bit16 sync, bit17 filtered
// - strobe route: bit24 sync, bit25 filtered
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module eic_top
  import eic_pkg::*;
#(
  parameter logic [EIC_FILT_W_BITS-1:0] FILT_W_DEF = EIC_FILT_W_RST
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire eic_enc_pins_t [EIC_UNITS-1:0] enc_pins_i,
  output eic_enc_pins_t [EIC_UNITS-1:0] unit_pins_o,
  output logic unit_clk_en_o,
  output logic phase_error_out_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic clk_dis;
    logic [31:0] route;
    logic err_sel;
    logic [EIC_FILT_W_BITS-1:0] filt_w;
    logic [EIC_UNITS-1:0] status;
    logic [EIC_UNITS-1:0] mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic perr_n;
    logic clk_en;
    logic irq;
  } eic_top_state_t;

  eic_top_state_t st_reg;
  eic_top_state_t st_next;
  eic_ahb_req_t req;
  logic [EIC_UNITS-1:0] unit_err;
  logic [EIC_UNITS*EIC_INPUTS-1:0] cond;
  logic [EIC_UNITS*EIC_INPUTS-1:0] raw;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign req = '{haddr: haddr_i, htrans: htrans_i, hwrite: hwrite_i, hsize: hsize_i,
                 hsel: hsel_i, hready: hready_i};
  assign addr_ok = req.hsel && req.hready && (req.htrans == EIC_HTRANS_NONSEQ || req.htrans == EIC_HTRANS_SEQ);

  // ------------------------------------------------------------
  // per unit, per input conditioning
  // ------------------------------------------------------------
  for (genvar u = 0; u < EIC_UNITS; u++) begin : g_unit
    for (genvar i = 0; i < EIC_INPUTS; i++) begin : g_in
      assign raw[u*EIC_INPUTS+i] = enc_pins_i[u][i];
      eic_sync_filter #(
        .W_BITS(EIC_FILT_W_BITS)
      ) u_sf (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i(raw[u*EIC_INPUTS+i]),
        .route_i(st_reg.route[i*EIC_ROUTE_STRIDE +: 2]),
        .width_i(st_reg.filt_w),
        .out_o(cond[u*EIC_INPUTS+i])
      );
      assign unit_pins_o[u][i] = cond[u*EIC_INPUTS+i];
    end
    eic_phase_check u_pc (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .en_i(st_reg.clk_en),
      .phase_a_i(cond[u*EIC_INPUTS]),
      .phase_b_i(cond[u*EIC_INPUTS+1]),
      .err_o(unit_err[u])
    );
  end

  // ------------------------------------------------------------
  // register file and bus
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    rd_mux = '0;
    // data phase of a write: zero wait states, so always completes here
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        EIC_OFS_CLK_DIS: begin
          st_next.clk_dis = hwdata_i[EIC_CLK_DIS_BIT];
        end
        EIC_OFS_ROUTE: begin
          st_next.route = hwdata_i;
        end
        EIC_OFS_ERR_SEL: begin
          st_next.err_sel = hwdata_i[0];
        end
        EIC_OFS_FILT_W: begin
          st_next.filt_w = hwdata_i[EIC_FILT_W_BITS-1:0];
        end
        EIC_OFS_STATUS: begin
          st_next.status = st_reg.status & ~hwdata_i[EIC_UNITS-1:0];
        end
        EIC_OFS_MASK: begin
          st_next.mask = hwdata_i[EIC_UNITS-1:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle clear
    st_next.status = st_next.status | unit_err;
    st_next.clk_en = !st_next.clk_dis;
    st_next.perr_n = !(st_reg.err_sel ? unit_err[1] : unit_err[0]);
    st_next.irq = |(st_next.status & st_next.mask);
    st_next.ready = 1'b1;
    // read data from next values so a write just before is seen
    case (req.haddr[7:0])
      EIC_OFS_CLK_DIS: begin
        rd_mux[EIC_CLK_DIS_BIT] = st_next.clk_dis;
      end
      EIC_OFS_ROUTE: begin
        rd_mux = st_next.route;
      end
      EIC_OFS_ERR_SEL: begin
        rd_mux[0] = st_next.err_sel;
      end
      EIC_OFS_FILT_W: begin
        rd_mux[EIC_FILT_W_BITS-1:0] = st_next.filt_w;
      end
      EIC_OFS_STATUS: begin
        rd_mux[EIC_UNITS-1:0] = st_next.status;
      end
      EIC_OFS_MASK: begin
        rd_mux[EIC_UNITS-1:0] = st_next.mask;
      end
      EIC_OFS_LEVELS: begin
        rd_mux[EIC_UNITS*EIC_INPUTS-1:0] = cond;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
    if (req.haddr[31:8] != '0) begin
      rd_mux = '0;
    end
    st_next.wr_pend = addr_ok && req.hwrite && (req.haddr[31:8] == '0);
    st_next.wr_addr = req.haddr[7:0];
    if (addr_ok && !req.hwrite) begin
      st_next.rdata = rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
      st_reg.clk_dis <= 1'b0;
      st_reg.clk_en <= 1'b1;
      st_reg.route <= EIC_ROUTE_RST;
      st_reg.filt_w <= FILT_W_DEF;
      st_reg.perr_n <= 1'b1;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata_o = st_reg.rdata;
  assign hreadyout_o = st_reg.ready;
  assign hresp_o = EIC_HRESP_OKAY;
  assign unit_clk_en_o = st_reg.clk_en;
  assign phase_error_out_o = st_reg.perr_n;
  assign irq_o = st_reg.irq;

endmodule
`default_nettype wire

/* sim/eic_top_chk.sv */
// port checker for eic_top: shadow of written config plus timing relations
// assumes one clk_i domain; bound into every eic_top below
`timescale 1ns/100ps
`default_nettype none
module eic_top_chk
  import eic_pkg::*;
#(
  parameter logic [EIC_FILT_W_BITS-1:0] FILT_W_DEF = EIC_FILT_W_RST
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire eic_enc_pins_t [EIC_UNITS-1:0] enc_pins_i,
  input wire eic_enc_pins_t [EIC_UNITS-1:0] unit_pins_o,
  input wire logic unit_clk_en_o,
  input wire logic phase_error_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------
  // config shadow
  // ----------------
  logic wr_q;
  logic [7:0] ofs_q;
  logic [31:0] route_q;
  logic sel_q;
  logic [7:0] fw_q;
  wire logic dp_w = wr_q && hready_i;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_q <= 1'b0;
      ofs_q <= 8'h00;
      route_q <= EIC_ROUTE_RST;
      sel_q <= 1'b0;
      fw_q <= FILT_W_DEF;
    end else begin
      if (hready_i) begin
        wr_q <= hsel_i && htrans_i[1] && hwrite_i && haddr_i[31:8] == 24'h00_0000;
        ofs_q <= haddr_i[7:0];
      end
      if (dp_w && ofs_q == EIC_OFS_ROUTE) route_q <= hwdata_i;
      if (dp_w && ofs_q == EIC_OFS_ERR_SEL) sel_q <= hwdata_i[0];
      if (dp_w && ofs_q == EIC_OFS_FILT_W) fw_q <= hwdata_i[7:0];
    end
  end
  // ----------------
  // sequences and assertions
  // ----------------
  sequence s_clk_wr;
    dp_w && ofs_q == EIC_OFS_CLK_DIS;
  endsequence
  sequence s_sync_held;
    ((route_q & 32'h0101_0101) == 32'h0101_0101) [*4];
  endsequence
  sequence s_filt_held;
    ((route_q & 32'h0303_0303) == 32'h0202_0202 && fw_q == 8'h03) [*8];
  endsequence
  // four enabled samples first: a stale stored phase would fake an error
  sequence s_tog(u);
    unit_clk_en_o [*4] ##0 sel_q == u && $changed(unit_pins_o[u].phase_a_input)
      && $changed(unit_pins_o[u].phase_b_input);
  endsequence
  a_clk_stop: assert property (s_clk_wr ##0 hwdata_i[EIC_CLK_DIS_BIT] |-> ##[1:2] !unit_clk_en_o)
    else $error("encoder clock still on");
  a_clk_run: assert property (s_clk_wr ##0 !hwdata_i[EIC_CLK_DIS_BIT] |-> ##[1:2] unit_clk_en_o)
    else $error("encoder clock still off");
  a_rst_run: assert property ($rose(rstn_i) |-> unit_clk_en_o && phase_error_out_o)
    else $error("bad state after reset");
  a_err_unit0: assert property (s_tog(1'b0) |-> ##[1:3] !phase_error_out_o)
    else $error("unit 0 error not forwarded");
  a_err_unit1: assert property (s_tog(1'b1) |-> ##[1:3] !phase_error_out_o)
    else $error("unit 1 error not forwarded");
  a_err_pulse: assert property ($fell(phase_error_out_o) |=> phase_error_out_o)
    else $error("error pulse too long");
  a_err_frozen: assert property (!unit_clk_en_o [*4] |-> phase_error_out_o)
    else $error("error while clock off");
  a_sync_path: assert property (s_sync_held |-> unit_pins_o == $past(enc_pins_i, 3))
    else $error("sync path mismatch");
  a_filt_hold: assert property (s_filt_held ##0 $changed(unit_pins_o[0].phase_a_input) |->
    $past(enc_pins_i[0].phase_a_input, 5) == unit_pins_o[0].phase_a_input
    && $past(enc_pins_i[0].phase_a_input, 6) == unit_pins_o[0].phase_a_input)
    else $error("filter passed unstable level");
endmodule
bind eic_top eic_top_chk #(.FILT_W_DEF(FILT_W_DEF)) chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .enc_pins_i(enc_pins_i), .unit_pins_o(unit_pins_o), .unit_clk_en_o(unit_clk_en_o),
  .phase_error_out_o(phase_error_out_o));
`default_nettype wire

/* sim/eic_enc_model.sv */
// behavioural incremental encoder driving raw pins of both units
// assumes drive() is entered just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module eic_enc_model
  import eic_pkg::*;
#(
  parameter int MIN_HOLD = 5
) (
  input wire logic clk_i,
  output var eic_enc_pins_t [EIC_UNITS-1:0] pins_o
);
  initial pins_o = '0;
  // short only when a bench case wants a glitch below filter width
  task automatic drive(input int u, input logic [3:0] v, input int hold, input bit short);
    int n;
    n = short ? hold : (hold < MIN_HOLD ? MIN_HOLD : hold);
    pins_o[u] <= v;
    repeat (n) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* sim/eic_tb_top.sv */
// self-checking bench for eic_top: registers, encoder traffic, error path
// assumes eic_enc_model as far side and the bound checker
`timescale 1ns/100ps
`default_nettype none
module eic_tb_top
  import eic_pkg::*;
;
  logic clk, rstn, hsel, hwrite, hready, hresp, clk_en, perr, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  eic_enc_pins_t [EIC_UNITS-1:0] pins, upins;
  int fails = 0;
  int num_checks = 0;
  int seed = 32'hfe5a;
  int n;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  eic_top dut_u (.clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .enc_pins_i(pins), .unit_pins_o(upins), .unit_clk_en_o(clk_en), .phase_error_out_o(perr), .irq_o(irq));
  eic_enc_model enc_u (.clk_i(clk), .pins_o(pins));
  // ----------------
  // tasks
  // ----------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    repeat (50) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    fails++;
    report_and_stop();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= EIC_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // both phases flip at once: an illegal step; n counts low cycles
  task automatic glitch(input int u);
    n = 0;
    fork
      enc_u.drive(u, pins[u] ^ 4'h3, 10, 1'b0);
      repeat (10) begin
        @(posedge clk);
        n += (perr === 1'b0) ? 1 : 0;
      end
    join
  endtask
  function automatic logic [3:0] quad_step(input logic [3:0] p, input bit up);
    return {p[3:2], up ? {p[0], ~p[1]} : {~p[0], p[1]}};
  endfunction
  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [31:0] r;
    logic [3:0] v;
    int u;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = '0;
    hwrite = 1'b0;
    hwdata = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({28'h0, hready, clk_en, perr, irq}, 32'h0000_000e);
    rdc(EIC_OFS_ROUTE, EIC_ROUTE_RST);
    rdc(EIC_OFS_CLK_DIS, 32'h0);
    rdc(EIC_OFS_FILT_W, {24'h0, EIC_FILT_W_RST});
    wr(8'h40, 32'hffff_ffff);
    rdc(8'h40, 32'h0);
    $display("test reset_regs done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      u = r[8];
      v = quad_step(pins[u], r[0]);
      v[3:2] = r[3:2];
      enc_u.drive(u, v, 2 + r[6:4], 1'b0);
      chk({28'h0, upins[u]}, {28'h0, v});
    end
    rdc(EIC_OFS_LEVELS, {24'h0, pins});
    $display("test quad_walk done");
    wr(EIC_OFS_MASK, 32'h2);
    rdc(EIC_OFS_MASK, 32'h2);
    for (int c = 0; c < 4; c++) begin
      wr(EIC_OFS_ERR_SEL, 32'(c >> 1));
      glitch(c & 1);
      chk(32'(n), 32'((c & 1) == (c >> 1)));
      rdc(EIC_OFS_STATUS, 32'(1 << (c & 1)));
      chk({31'h0, irq}, 32'(c & 1));
      wr(EIC_OFS_STATUS, 32'h3);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test phase_error done");
    wr(EIC_OFS_CLK_DIS, 32'h0000_0200);
    rdc(EIC_OFS_CLK_DIS, 32'h0000_0200);
    chk({31'h0, clk_en}, 32'h0);
    glitch(1);
    chk(32'(n), 32'h0);
    chk({28'h0, upins[1]}, {28'h0, pins[1]});
    wr(EIC_OFS_CLK_DIS, 32'h0);
    // enable is launched at the write's last edge, seen one edge on
    @(posedge clk);
    chk({31'h0, clk_en}, 32'h1);
    repeat (6) @(posedge clk);
    glitch(1);
    chk(32'(n), 32'h1);
    wr(EIC_OFS_STATUS, 32'h3);
    $display("test clock_gate done");
    wr(EIC_OFS_ROUTE, 32'h0202_0202);
    v = pins[0];
    enc_u.drive(0, v ^ 4'h1, 1, 1'b1);
    enc_u.drive(0, v, 12, 1'b0);
    chk({28'h0, upins[0]}, {28'h0, v});
    enc_u.drive(0, v ^ 4'h1, 12, 1'b0);
    chk({28'h0, upins[0]}, {28'h0, v ^ 4'h1});
    $display("test filter done");
    report_and_stop();
  end
endmodule
`default_nettype wire
